// [include/ddr2_regs.svh]
// constants for the ddr2 command decoder and bank tracker
// How it works
// [RULE_01] every command comes from cs, ras, cas, we and cke at the clock edge
// [RULE_02] deselect continues the current operation; cs low with the rest high is nop
// [RULE_03] load mode is all strobes low, cke high; bank picks register, address is opcode
// [RULE_04] a bank is idle after precharge time and any read burst has ended
// [RULE_05] activate is cs and ras low; bank address picks bank, address is the row
// [RULE_06] a bank becomes row active once the activate-to-column delay has passed
// [RULE_07] read is ras high, cas low, we high; a10 high asks for auto precharge
// [RULE_08] write is ras high, cas and we low; a10 high asks for auto precharge
// [RULE_09] precharge closes one bank, or every bank with a10 high ignoring bank address
// [RULE_10] a row active bank takes read, write and precharge
// [RULE_11] during a plain read burst the bank takes read, write or precharge
// [RULE_12] during a plain write burst the bank takes read, write or precharge
// [RULE_13] precharge during a read or write state starts closing the row
// [RULE_14] read or write state means a burst without auto precharge still running
// [RULE_15] the third bank address bit is used only on the larger densities
// [RULE_16] unused upper address bits are ignored during column addressing
// [RULE_17] self refresh enters on refresh with cke falling, leaves on cke rising
// [RULE_18] power-down follows cke with deselect or nop; it does no refresh
// [RULE_19] four-beat bursts are never cut short by a later command
// [RULE_20] termination does not affect decoding and is off in self refresh
// [RULE_21] bank checks apply only with cke high twice and after self refresh exit delay
// [RULE_22] a bank in a transitional state takes only deselect or nop
// [RULE_23] refresh and load mode are issued only with every bank idle
// [RULE_24] any state and command pair not listed is illegal
// [RULE_25] a command that the target bank state forbids is flagged
`ifndef DDR2_REGS_SVH
`define DDR2_REGS_SVH
`define CLK_NS 20
`define T_RCD_NS 15
`define T_RP_NS 15
`define T_WR_NS 15
`define T_RFC_NS 128
`define T_XSNR_NS 138
`define CEIL_CYC(ns) 8'((((ns) + `CLK_NS - 1) / `CLK_NS))
`define T_RCD_CYC `CEIL_CYC(`T_RCD_NS)
`define T_RP_CYC `CEIL_CYC(`T_RP_NS)
`define T_WR_CYC `CEIL_CYC(`T_WR_NS)
`define T_RFC_CYC `CEIL_CYC(`T_RFC_NS)
`define T_XSNR_CYC `CEIL_CYC(`T_XSNR_NS)
`define T_MRD_CYC 8'h02
`define BURST_CYC 8'h02
`define ENC_LOAD_MODE 3'h0
`define ENC_REFRESH 3'h1
`define ENC_PRECHARGE 3'h2
`define ENC_ACTIVATE 3'h3
`define ENC_WRITE 3'h4
`define ENC_READ 3'h5
`define ENC_NOP 3'h7
`define A10_BIT 10
`define ADDR_W 14
`define BA_W 3
`define NUM_BANKS 8
`endif

// [include/ddr2_pkg.sv]
// types shared by the ddr2 command decoder and bank tracker
package ddr2_pkg;
  typedef enum logic [3:0] {
    CMD_DESEL, CMD_NOP, CMD_LOAD_MODE, CMD_REFRESH, CMD_SREF_ENTRY,
    CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_PRECHARGE, CMD_PD_ENTRY,
    CMD_CKE_EXIT, CMD_RESERVED
  } cmd_e;
  typedef enum logic [2:0] {
    BANK_IDLE, BANK_ACTIVATING, BANK_ROW_ACTIVE, BANK_READ, BANK_WRITE,
    BANK_ACCESS_AP, BANK_PRECHARGING
  } bank_e;
  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_DOWN, PWR_SREF, PWR_SREF_EXIT
  } pwr_e;
endpackage

// [hdl/interval_timer.sv]
// down-counting timer for device-wide waits
`timescale 1ns/100ps
module interval_timer (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // load and status
  input  wire logic       load,
  input  wire logic [7:0] cycles,
  output logic            busy
);
  logic [7:0] cnt_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= 8'h00;
    end else if (load) begin
      cnt_reg <= cycles;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // busy stands exactly cycles clocks after load
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= load || (cnt_reg > 8'h01);
    end
  end
endmodule

// [hdl/bank_tracker.sv]
// per-bank state tracker with burst and precharge timing
`timescale 1ns/100ps
`include "ddr2_regs.svh"
module bank_tracker (
  // clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst,
  // command steered to this bank
  input  wire logic           hit,
  input  wire ddr2_pkg::cmd_e cmd,
  input  wire logic           auto_pre,
  input  wire logic           pre_all,
  // bank status
  output ddr2_pkg::bank_e     state,
  output logic                reject
);
  ddr2_pkg::bank_e state_next;
  logic [7:0]      cnt_reg;
  logic [7:0]      cnt_next;
  logic            is_wr_reg;
  logic            is_rw;

  function automatic ddr2_pkg::bank_e burst_state(input ddr2_pkg::cmd_e c, input logic ap);
    if (ap) return ddr2_pkg::BANK_ACCESS_AP;
    return (c == ddr2_pkg::CMD_READ) ? ddr2_pkg::BANK_READ : ddr2_pkg::BANK_WRITE;
  endfunction

  always_comb begin
    state_next = state;
    cnt_next = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
    reject = 1'b0;
    is_rw = cmd inside {ddr2_pkg::CMD_READ, ddr2_pkg::CMD_WRITE};
    unique case (state)
      ddr2_pkg::BANK_IDLE: begin
        if (hit && cmd == ddr2_pkg::CMD_ACTIVATE) begin  // [RULE_04] [RULE_05]
          state_next = ddr2_pkg::BANK_ACTIVATING;
          cnt_next = `T_RCD_CYC - 8'h01;
        end else if (hit && !pre_all) begin
          reject = 1'b1;  // [RULE_25]
        end
      end
      ddr2_pkg::BANK_ACTIVATING, ddr2_pkg::BANK_PRECHARGING: begin
        reject = hit;  // [RULE_22]
        if (cnt_reg == 8'h00) begin  // [RULE_06] [RULE_04]
          state_next = (state == ddr2_pkg::BANK_ACTIVATING) ?
                       ddr2_pkg::BANK_ROW_ACTIVE : ddr2_pkg::BANK_IDLE;
        end
      end
      ddr2_pkg::BANK_ACCESS_AP: begin
        reject = hit;  // [RULE_22]
        if (cnt_reg == 8'h00) begin
          state_next = ddr2_pkg::BANK_PRECHARGING;
          cnt_next = is_wr_reg ? `T_WR_CYC + `T_RP_CYC - 8'h01 : `T_RP_CYC - 8'h01;
        end
      end
      default: begin
        // row active, read and write share the column command handling
        if (hit && state != ddr2_pkg::BANK_ROW_ACTIVE && cnt_reg != 8'h00) begin
          reject = 1'b1;  // [RULE_19]
        end else if (hit && is_rw) begin  // [RULE_10] [RULE_11] [RULE_12]
          state_next = burst_state(cmd, auto_pre);
          cnt_next = `BURST_CYC - 8'h01;
        end else if (hit && cmd == ddr2_pkg::CMD_PRECHARGE) begin  // [RULE_13]
          state_next = ddr2_pkg::BANK_PRECHARGING;
          cnt_next = `T_RP_CYC - 8'h01;
        end else if (hit) begin
          reject = 1'b1;  // [RULE_24]
        end else if (state != ddr2_pkg::BANK_ROW_ACTIVE && cnt_reg == 8'h00) begin
          state_next = ddr2_pkg::BANK_ROW_ACTIVE;  // [RULE_14]
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ddr2_pkg::BANK_IDLE;
      cnt_reg <= 8'h00;
    end else begin
      state <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      is_wr_reg <= 1'b0;
    end else if (hit && is_rw && !reject) begin
      is_wr_reg <= (cmd == ddr2_pkg::CMD_WRITE);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  open_delay_a: assert property (  // [RULE_06]
    state == ddr2_pkg::BANK_IDLE && hit && cmd == ddr2_pkg::CMD_ACTIVATE
    |=> state == ddr2_pkg::BANK_ACTIVATING ##[1:8] state == ddr2_pkg::BANK_ROW_ACTIVE
  ) else $error("activated bank never opened");

  burst_hold_a: assert property (  // [RULE_19]
    state inside {ddr2_pkg::BANK_READ, ddr2_pkg::BANK_WRITE} && cnt_reg != 8'h00 && hit
    |-> reject ##1 state == $past(state)
  ) else $error("running burst was cut short");

  close_idle_a: assert property (  // [RULE_04]
    state == ddr2_pkg::BANK_PRECHARGING |-> ##[1:16] state == ddr2_pkg::BANK_IDLE
  ) else $error("precharging bank never went idle");

  ap_cycle_c: cover property (
    state == ddr2_pkg::BANK_ACCESS_AP ##[1:16] state == ddr2_pkg::BANK_IDLE
  );
endmodule

// [hdl/ddr2_cmd_decoder.sv]
// command decoder, power state and bank tracking for a ddr2 device
`timescale 1ns/100ps
`include "ddr2_regs.svh"

module ddr2_cmd_decoder (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // command and address pins
  input  wire logic               cke,
  input  wire logic               cs_n,
  input  wire logic               ras_n,
  input  wire logic               cas_n,
  input  wire logic               we_n,
  input  wire logic [`BA_W-1:0]   ba,
  input  wire logic [`ADDR_W-1:0] addr,
  input  wire logic               odt,
  // configuration
  input  wire logic               ba2_used,
  input  wire logic [3:0]         col_bits,
  // decoded command
  output ddr2_pkg::cmd_e          cmd_code,
  output logic [`BA_W-1:0]        cmd_bank,
  output logic [`ADDR_W-1:0]      cmd_addr,
  output logic                    cmd_auto_pre,
  output logic                    illegal_cmd,
  // mode register load
  output logic                    mode_load,
  output logic [`BA_W-1:0]        mode_sel,
  output logic [`ADDR_W-1:0]      mode_op,
  // device and bank status
  output ddr2_pkg::pwr_e          pwr_state,
  output logic                    dev_busy,
  output logic                    odt_active,
  output logic [`NUM_BANKS-1:0]   bank_idle,
  output logic [`NUM_BANKS-1:0]   bank_open
);
  logic                  cke_prev_reg;
  ddr2_pkg::cmd_e        cmd_now;
  logic                  gate_ok;
  logic                  nop_cmd;
  logic                  all_idle;
  logic [`BA_W-1:0]      bank_sel;
  logic                  pre_all;
  logic                  bank_cmd;
  logic                  col_cmd;
  logic [`NUM_BANKS-1:0] hit;
  logic [`NUM_BANKS-1:0] reject;
  logic [`NUM_BANKS-1:0] idle_now;
  logic [`NUM_BANKS-1:0] open_now;
  ddr2_pkg::bank_e       state [`NUM_BANKS];
  logic                  dev_reject;
  logic                  timer_load;
  logic [7:0]            timer_cycles;
  ddr2_pkg::pwr_e        pwr_next;

  // cke is compared with its own value one edge earlier
  function automatic ddr2_pkg::cmd_e decode(
    input logic       ck_prev,
    input logic       ck_now,
    input logic [3:0] pins
  );
    logic idle_enc;
    idle_enc = pins[3] || (pins[2:0] == `ENC_NOP);
    if (ck_prev && !ck_now) begin
      if (!pins[3] && pins[2:0] == `ENC_REFRESH) begin
        return ddr2_pkg::CMD_SREF_ENTRY;  // [RULE_17]
      end
      return idle_enc ? ddr2_pkg::CMD_PD_ENTRY : ddr2_pkg::CMD_RESERVED;  // [RULE_18]
    end
    if (!ck_prev && ck_now) begin
      return idle_enc ? ddr2_pkg::CMD_CKE_EXIT : ddr2_pkg::CMD_RESERVED;
    end
    if (!ck_now || pins[3]) begin
      return ddr2_pkg::CMD_DESEL;  // [RULE_02]
    end
    unique case (pins[2:0])
      `ENC_NOP:        return ddr2_pkg::CMD_NOP;  // [RULE_02]
      `ENC_LOAD_MODE:  return ddr2_pkg::CMD_LOAD_MODE;  // [RULE_03]
      `ENC_REFRESH:    return ddr2_pkg::CMD_REFRESH;
      `ENC_ACTIVATE:   return ddr2_pkg::CMD_ACTIVATE;  // [RULE_05]
      `ENC_READ:       return ddr2_pkg::CMD_READ;  // [RULE_07]
      `ENC_WRITE:      return ddr2_pkg::CMD_WRITE;  // [RULE_08]
      `ENC_PRECHARGE:  return ddr2_pkg::CMD_PRECHARGE;  // [RULE_09]
      default:         return ddr2_pkg::CMD_RESERVED;  // [RULE_24]
    endcase
  endfunction

  // a10 is the auto precharge flag, never a column bit
  function automatic logic [`ADDR_W-1:0] col_mask(
    input logic [`ADDR_W-1:0] a,
    input logic [3:0]         w
  );
    logic [`ADDR_W-1:0] m;
    m = '0;
    for (int i = 0; i < `ADDR_W; i++) begin
      if (i < `A10_BIT) begin
        m[i] = a[i] && (4'(i) < w);
      end else if (i > `A10_BIT) begin
        m[i] = a[i] && (4'(i - 1) < w);
      end
    end
    return m;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cke_prev_reg <= 1'b0;
    end else begin
      cke_prev_reg <= cke;
    end
  end

  assign cmd_now = decode(cke_prev_reg, cke, {cs_n, ras_n, cas_n, we_n});  // [RULE_01]
  assign nop_cmd = cmd_now inside {ddr2_pkg::CMD_DESEL, ddr2_pkg::CMD_NOP,
                                   ddr2_pkg::CMD_CKE_EXIT};
  // odt plays no part here, so decoding cannot depend on it
  assign gate_ok = pwr_state == ddr2_pkg::PWR_ACTIVE && !dev_busy
                   && cke_prev_reg && cke;  // [RULE_21] [RULE_20]
  assign bank_sel = ba2_used ? ba : {1'b0, ba[`BA_W-2:0]};  // [RULE_15]
  assign pre_all = cmd_now == ddr2_pkg::CMD_PRECHARGE && addr[`A10_BIT];  // [RULE_09]
  assign col_cmd = cmd_now inside {ddr2_pkg::CMD_READ, ddr2_pkg::CMD_WRITE};
  assign bank_cmd = gate_ok && (col_cmd || cmd_now inside {ddr2_pkg::CMD_ACTIVATE,
                                                           ddr2_pkg::CMD_PRECHARGE});
  assign all_idle = &idle_now;

  for (genvar b = 0; b < `NUM_BANKS; b++) begin : g_bank
    assign hit[b] = bank_cmd && (bank_sel == `BA_W'(b) || pre_all);  // [RULE_09]
    assign idle_now[b] = state[b] == ddr2_pkg::BANK_IDLE;
    assign open_now[b] = state[b] inside {ddr2_pkg::BANK_ROW_ACTIVE, ddr2_pkg::BANK_READ,
                                          ddr2_pkg::BANK_WRITE, ddr2_pkg::BANK_ACCESS_AP};
    bank_tracker u_bank (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .hit      (hit[b]),
      .cmd      (cmd_now),
      .auto_pre (addr[`A10_BIT]),
      .pre_all  (pre_all),
      .state    (state[b]),
      .reject   (reject[b])
    );
  end

  // one shared timer covers refresh, mode load and self refresh exit,
  // which never overlap
  interval_timer u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (timer_load),
    .cycles  (timer_cycles),
    .busy    (dev_busy)
  );

  always_comb begin
    pwr_next = pwr_state;
    dev_reject = 1'b0;
    timer_load = 1'b0;
    timer_cycles = `T_MRD_CYC;
    unique case (pwr_state)
      ddr2_pkg::PWR_ACTIVE: begin
        if (cmd_now == ddr2_pkg::CMD_RESERVED) begin
          dev_reject = 1'b1;  // [RULE_24]
        end else if (dev_busy && !nop_cmd) begin
          dev_reject = 1'b1;  // [RULE_22]
        end else begin
          unique case (cmd_now)
            ddr2_pkg::CMD_LOAD_MODE: begin
              dev_reject = !all_idle;  // [RULE_23] [RULE_25]
              timer_load = all_idle;  // [RULE_03]
            end
            ddr2_pkg::CMD_REFRESH: begin
              dev_reject = !all_idle;  // [RULE_23] [RULE_25]
              timer_load = all_idle;
              timer_cycles = `T_RFC_CYC;
            end
            ddr2_pkg::CMD_SREF_ENTRY: begin
              dev_reject = !all_idle;  // [RULE_23]
              if (all_idle) begin
                pwr_next = ddr2_pkg::PWR_SREF;  // [RULE_17]
              end
            end
            ddr2_pkg::CMD_PD_ENTRY: begin
              pwr_next = ddr2_pkg::PWR_DOWN;  // [RULE_18]
            end
            default: begin
              dev_reject = 1'b0;
            end
          endcase
        end
      end
      ddr2_pkg::PWR_DOWN: begin
        // no refresh happens here; the controller bounds the stay
        if (cmd_now == ddr2_pkg::CMD_CKE_EXIT) begin
          pwr_next = ddr2_pkg::PWR_ACTIVE;  // [RULE_18]
        end
        dev_reject = cmd_now == ddr2_pkg::CMD_RESERVED;
      end
      ddr2_pkg::PWR_SREF: begin
        // exit is seen at the first edge with cke high again
        if (cmd_now == ddr2_pkg::CMD_CKE_EXIT) begin
          pwr_next = ddr2_pkg::PWR_SREF_EXIT;  // [RULE_17]
          timer_load = 1'b1;
          timer_cycles = `T_XSNR_CYC;
        end
        dev_reject = cmd_now == ddr2_pkg::CMD_RESERVED;
      end
      ddr2_pkg::PWR_SREF_EXIT: begin
        dev_reject = !nop_cmd;  // [RULE_21]
        if (!dev_busy) begin
          pwr_next = ddr2_pkg::PWR_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwr_state <= ddr2_pkg::PWR_ACTIVE;
    end else begin
      pwr_state <= pwr_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_code <= ddr2_pkg::CMD_DESEL;
      cmd_bank <= '0;
      cmd_addr <= '0;
      cmd_auto_pre <= 1'b0;
    end else begin
      cmd_code <= cmd_now;
      cmd_bank <= bank_sel;
      cmd_addr <= col_cmd ? col_mask(addr, col_bits) : addr;  // [RULE_16]
      cmd_auto_pre <= (col_cmd || pre_all) && addr[`A10_BIT];  // [RULE_07] [RULE_08]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      illegal_cmd <= 1'b0;
    end else begin
      illegal_cmd <= dev_reject || (|reject);  // [RULE_25]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_load <= 1'b0;
      mode_sel <= '0;
      mode_op <= '0;
    end else begin
      mode_load <= gate_ok && cmd_now == ddr2_pkg::CMD_LOAD_MODE && all_idle;  // [RULE_03]
      mode_sel <= bank_sel;
      mode_op <= addr;
    end
  end

  // termination is cut as self refresh begins, not one edge later
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      odt_active <= 1'b0;
    end else begin
      odt_active <= odt && pwr_next != ddr2_pkg::PWR_SREF;  // [RULE_20]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bank_idle <= '1;
      bank_open <= '0;
    end else begin
      bank_idle <= idle_now;
      bank_open <= open_now;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  deselect_quiet_a: assert property (  // [RULE_02]
    cke_prev_reg && cke && cs_n
    |=> cmd_code == ddr2_pkg::CMD_DESEL && !illegal_cmd && !mode_load
  ) else $error("deselect did something");

  mode_load_a: assert property (  // [RULE_03]
    gate_ok && cmd_now == ddr2_pkg::CMD_LOAD_MODE && all_idle
    |=> mode_load && mode_sel == $past(bank_sel) && mode_op == $past(addr) ##1 dev_busy
  ) else $error("load mode not passed on");

  sref_entry_a: assert property (  // [RULE_17]
    pwr_state == ddr2_pkg::PWR_ACTIVE && !dev_busy && all_idle
    && cmd_now == ddr2_pkg::CMD_SREF_ENTRY
    |=> pwr_state == ddr2_pkg::PWR_SREF
  ) else $error("self refresh not entered");

  sref_exit_a: assert property (  // [RULE_21]
    pwr_state == ddr2_pkg::PWR_SREF && cmd_now == ddr2_pkg::CMD_CKE_EXIT
    |=> pwr_state == ddr2_pkg::PWR_SREF_EXIT && dev_busy ##[1:300] !dev_busy
  ) else $error("self refresh exit wait wrong");

  exit_gate_a: assert property (  // [RULE_21]
    pwr_state == ddr2_pkg::PWR_SREF_EXIT && !nop_cmd |=> illegal_cmd
  ) else $error("command during exit wait not flagged");

  pdown_a: assert property (  // [RULE_18]
    pwr_state == ddr2_pkg::PWR_ACTIVE && !dev_busy && cmd_now == ddr2_pkg::CMD_PD_ENTRY
    |=> pwr_state == ddr2_pkg::PWR_DOWN
  ) else $error("power-down not entered");

  odt_off_a: assert property (  // [RULE_20]
    pwr_state == ddr2_pkg::PWR_SREF |-> !odt_active
  ) else $error("termination on in self refresh");

  refresh_gate_a: assert property (  // [RULE_25]
    gate_ok && cmd_now == ddr2_pkg::CMD_REFRESH && !all_idle |=> illegal_cmd && !dev_busy
  ) else $error("refresh with open bank not flagged");

  col_addr_a: assert property (  // [RULE_16]
    gate_ok && col_cmd
    |=> !cmd_addr[`A10_BIT] && cmd_auto_pre == $past(addr[`A10_BIT])
  ) else $error("column address not cleaned");

  pre_all_a: assert property (  // [RULE_09]
    pre_all && bank_cmd && reject == '0 |=> open_now == '0
  ) else $error("precharge all left a bank open");

  reserved_a: assert property (  // [RULE_24]
    cmd_now == ddr2_pkg::CMD_RESERVED |=> illegal_cmd
  ) else $error("reserved command not flagged");

  sref_trip_c: cover property (
    pwr_state == ddr2_pkg::PWR_SREF ##[1:50] pwr_state == ddr2_pkg::PWR_ACTIVE
  );
  mode_load_c: cover property (mode_load);
  read_ap_c: cover property (gate_ok && cmd_now == ddr2_pkg::CMD_READ && addr[`A10_BIT]);
  pdown_c: cover property (pwr_state == ddr2_pkg::PWR_DOWN);
endmodule

// [verif/ctrl_model.sv]
// controller-side model that turns bench requests into command pins
`timescale 1ns/100ps
`include "ddr2_regs.svh"
module ctrl_model (
  // clock and bench request
  input  wire logic               ref_clk,
  input  wire ddr2_pkg::cmd_e     op,
  input  wire logic [`BA_W-1:0]   bank,
  input  wire logic [`ADDR_W-1:0] a,
  // command pins
  output logic                    cs_n,
  output logic                    ras_n,
  output logic                    cas_n,
  output logic                    we_n,
  output logic [`BA_W-1:0]        ba,
  output logic [`ADDR_W-1:0]      addr
);
  logic [`ADDR_W-1:0] last_a_reg = '0;
  logic [2:0]         enc;
  always_ff @(posedge ref_clk) begin
    if (op != ddr2_pkg::CMD_DESEL) begin
      last_a_reg <= a;
    end
  end
  always_comb begin
    case (op)
      ddr2_pkg::CMD_LOAD_MODE:  enc = `ENC_LOAD_MODE;
      ddr2_pkg::CMD_REFRESH:    enc = `ENC_REFRESH;
      ddr2_pkg::CMD_SREF_ENTRY: enc = `ENC_REFRESH;
      ddr2_pkg::CMD_ACTIVATE:   enc = `ENC_ACTIVATE;
      ddr2_pkg::CMD_READ:       enc = `ENC_READ;
      ddr2_pkg::CMD_WRITE:      enc = `ENC_WRITE;
      ddr2_pkg::CMD_PRECHARGE:  enc = `ENC_PRECHARGE;
      ddr2_pkg::CMD_RESERVED:   enc = 3'h6;
      default:                  enc = `ENC_NOP;
    endcase
  end
  assign cs_n = (op == ddr2_pkg::CMD_DESEL);
  assign {ras_n, cas_n, we_n} = enc;
  // unselected cycles show inverted values so stale bits never look valid
  assign ba   = cs_n ? ~bank : bank;
  assign addr = cs_n ? ~last_a_reg : a;
endmodule

// [verif/tb_ddr2_cmd_decoder.sv]
// self-checking bench for the ddr2 command decoder
`timescale 1ns/100ps
`include "ddr2_regs.svh"
module tb_ddr2_cmd_decoder;
  logic                  ref_clk, rst, cke, odt, ba2_used;
  logic [3:0]            col_bits;
  ddr2_pkg::cmd_e        op_r, cmd_code;
  ddr2_pkg::pwr_e        pwr_state;
  logic [`BA_W-1:0]      ba_r, ba, cmd_bank, mode_sel;
  logic [`ADDR_W-1:0]    a_r, addr, cmd_addr, mode_op;
  logic                  cs_n, ras_n, cas_n, we_n;
  logic                  cmd_auto_pre, illegal_cmd, mode_load, dev_busy, odt_active;
  logic [`NUM_BANKS-1:0] bank_idle, bank_open;
  int                    err_total = 0, tests_run = 0, ill_cnt = 0, base;
  ctrl_model ctrl_model_i (.ref_clk, .op(op_r), .bank(ba_r), .a(a_r), .cs_n, .ras_n,
    .cas_n, .we_n, .ba, .addr);
  ddr2_cmd_decoder ddr2_cmd_decoder_i (.ref_clk, .rst, .cke, .cs_n, .ras_n, .cas_n, .we_n,
    .ba, .addr, .odt, .ba2_used, .col_bits, .cmd_code, .cmd_bank, .cmd_addr, .cmd_auto_pre,
    .illegal_cmd, .mode_load, .mode_sel, .mode_op, .pwr_state, .dev_busy, .odt_active,
    .bank_idle, .bank_open);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    if (illegal_cmd === 1'b1) ill_cnt++;
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cmd(input ddr2_pkg::cmd_e o, input logic [2:0] b, input logic [13:0] a,
                     input logic c = 1'b1);
    @(posedge ref_clk);
    op_r <= o;
    ba_r <= b;
    a_r  <= a;
    cke  <= c;
  endtask
  task automatic nops(input int n);
    repeat (n) cmd(ddr2_pkg::CMD_NOP, 3'h0, 14'h0);
  endtask
  task automatic final_report;
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_read;
    base = ill_cnt;
    cmd(ddr2_pkg::CMD_ACTIVATE, 3'h1, 14'h1234);
    nops(1);
    @(negedge ref_clk);
    chk("cmd_code", cmd_code, ddr2_pkg::CMD_ACTIVATE);
    chk("cmd_addr", cmd_addr, 14'h1234);
    cmd(ddr2_pkg::CMD_READ, 3'h1, 14'h3805);
    // lands on the first burst cycle, so it would truncate the burst
    cmd(ddr2_pkg::CMD_READ, 3'h1, 14'h0001);
    @(negedge ref_clk);
    chk("cmd_code", cmd_code, ddr2_pkg::CMD_READ);
    chk("cmd_addr", cmd_addr, 14'h0005);
    chk("cmd_bank", cmd_bank, 3'h1);
    cmd(ddr2_pkg::CMD_READ, 3'h1, 14'h0402);
    nops(1);
    @(negedge ref_clk);
    chk("auto_pre", cmd_auto_pre, 1'b1);
    nops(6);
    @(negedge ref_clk);
    chk("bank_idle", bank_idle, 8'hff);
    chk("illegal", 16'(ill_cnt - base), 16'h1);
  endtask
  task automatic t_write;
    base = ill_cnt;
    cmd(ddr2_pkg::CMD_ACTIVATE, 3'h2, 14'h0077);
    col_bits <= 4'hb;
    nops(1);
    cmd(ddr2_pkg::CMD_WRITE, 3'h2, 14'h3810);
    nops(1);
    @(negedge ref_clk);
    chk("cmd_addr", cmd_addr, 14'h0810);
    cmd(ddr2_pkg::CMD_READ, 3'h2, 14'h0020);
    nops(1);
    cmd(ddr2_pkg::CMD_PRECHARGE, 3'h2, 14'h0000);
    nops(1);
    @(negedge ref_clk);
    chk("bank_idle2", bank_idle[2], 1'b0);
    chk("bank_open", bank_open, 8'h04);
    nops(3);
    @(negedge ref_clk);
    chk("bank_idle", bank_idle, 8'hff);
    chk("illegal", 16'(ill_cnt - base), 16'h0);
  endtask
  task automatic t_illegal;
    base = ill_cnt;
    cmd(ddr2_pkg::CMD_PRECHARGE, 3'h3, 14'h0000);
    cmd(ddr2_pkg::CMD_RESERVED, 3'h0, 14'h0000);
    cmd(ddr2_pkg::CMD_ACTIVATE, 3'h4, 14'h0100);
    nops(2);
    cmd(ddr2_pkg::CMD_REFRESH, 3'h0, 14'h0000);
    cmd(ddr2_pkg::CMD_ACTIVATE, 3'h4, 14'h0200);
    cmd(ddr2_pkg::CMD_PRECHARGE, 3'h0, 14'h0400);
    nops(3);
    @(negedge ref_clk);
    chk("bank_idle", bank_idle, 8'hff);
    chk("illegal", 16'(ill_cnt - base), 16'h4);
  endtask
  task automatic t_mode;
    base = ill_cnt;
    cmd(ddr2_pkg::CMD_LOAD_MODE, 3'h5, 14'h0a5a);
    cmd(ddr2_pkg::CMD_ACTIVATE, 3'h0, 14'h0000);
    @(negedge ref_clk);
    chk("mode_load", mode_load, 1'b1);
    chk("mode_sel", mode_sel, 3'h5);
    chk("mode_op", mode_op, 14'h0a5a);
    chk("dev_busy", dev_busy, 1'b1);
    nops(4);
    @(negedge ref_clk);
    chk("illegal", 16'(ill_cnt - base), 16'h1);
    chk("dev_busy", dev_busy, 1'b0);
    cmd(ddr2_pkg::CMD_REFRESH, 3'h0, 14'h0);
    nops(7);
    @(negedge ref_clk);
    chk("dev_busy", dev_busy, 1'b1);
    nops(1);
    @(negedge ref_clk);
    chk("dev_busy", dev_busy, 1'b0);
  endtask
  task automatic t_mask;
    @(posedge ref_clk);
    ba2_used <= 1'b0;
    cmd(ddr2_pkg::CMD_ACTIVATE, 3'h5, 14'h0000);
    nops(1);
    @(negedge ref_clk);
    chk("cmd_bank", cmd_bank, 3'h1);
    nops(1);
    cmd(ddr2_pkg::CMD_PRECHARGE, 3'h0, 14'h0400);
    nops(3);
    @(negedge ref_clk);
    chk("bank_idle", bank_idle, 8'hff);
    @(posedge ref_clk);
    ba2_used <= 1'b1;
  endtask
  task automatic t_power;
    base = ill_cnt;
    cmd(ddr2_pkg::CMD_SREF_ENTRY, 3'h0, 14'h0, 1'b0);
    cmd(ddr2_pkg::CMD_DESEL, 3'h0, 14'h0, 1'b0);
    @(negedge ref_clk);
    chk("pwr_state", pwr_state, ddr2_pkg::PWR_SREF);
    chk("odt_active", odt_active, 1'b0);
    cmd(ddr2_pkg::CMD_DESEL, 3'h0, 14'h0, 1'b0);
    cmd(ddr2_pkg::CMD_CKE_EXIT, 3'h0, 14'h0);
    cmd(ddr2_pkg::CMD_ACTIVATE, 3'h0, 14'h0);
    @(negedge ref_clk);
    chk("pwr_state", pwr_state, ddr2_pkg::PWR_SREF_EXIT);
    nops(10);
    @(negedge ref_clk);
    chk("pwr_state", pwr_state, ddr2_pkg::PWR_ACTIVE);
    chk("illegal", 16'(ill_cnt - base), 16'h1);
    cmd(ddr2_pkg::CMD_PD_ENTRY, 3'h0, 14'h0, 1'b0);
    cmd(ddr2_pkg::CMD_DESEL, 3'h0, 14'h0, 1'b0);
    @(negedge ref_clk);
    chk("pwr_state", pwr_state, ddr2_pkg::PWR_DOWN);
    chk("odt_active", odt_active, 1'b1);
    cmd(ddr2_pkg::CMD_CKE_EXIT, 3'h0, 14'h0);
    nops(2);
    @(negedge ref_clk);
    chk("pwr_state", pwr_state, ddr2_pkg::PWR_ACTIVE);
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    cke = 1'b1;
    odt = 1'b1;
    ba2_used = 1'b1;
    col_bits = 4'ha;
    op_r = ddr2_pkg::CMD_NOP;
    ba_r = '0;
    a_r = '0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("cmd_code", cmd_code, ddr2_pkg::CMD_DESEL);
    chk("bank_idle", bank_idle, 8'hff);
    nops(2);
    t_read();
    t_write();
    t_illegal();
    t_mode();
    t_mask();
    t_power();
    final_report();
  end
endmodule
